//--- hdl/bscan_pkg.sv
package bscan_pkg;

    // Instruction register
    localparam int IR_W = 6;
    localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
    localparam logic [IR_W-1:0] OP_IDCODE = 6'h02;
    localparam logic [IR_W-1:0] OP_HIGHZ = 6'h03;
    localparam logic [IR_W-1:0] OP_CLAMP = 6'h3e;
    localparam logic [IR_W-1:0] OP_BYPASS = 6'h3f;
    localparam logic [IR_W-1:0] IR_CAPTURE_PATTERN = 6'h2d;

    // Identification register layout
    localparam int ID_W = 32;
    localparam int MAKER_W = 11;
    localparam int PART_W = 16;
    localparam int VER_W = 4;
    localparam logic ID_FIXED_LSB = 1'b1;

    // Positions inside the synchroniser vector
    localparam int SYN_TCK = 0;
    localparam int SYN_TDI = 1;
    localparam int SYN_TRST_N = 2;
    localparam int SYN_TAP_RESET = 3;
    localparam int SYN_CAP_IR = 4;
    localparam int SYN_SH_IR = 5;
    localparam int SYN_UPD_IR = 6;
    localparam int SYN_CAP_DR = 7;
    localparam int SYN_SH_DR = 8;
    localparam int SYN_UPD_DR = 9;
    localparam int SYN_PIN = 10;

    // Data register selected between serial in and out
    typedef enum logic [1:0] {
        SEL_BYPASS,
        SEL_CHAIN,
        SEL_ID
    } dr_sel_t;

endpackage : bscan_pkg

//--- hdl/bscan_ir_dr.sv
`timescale 1ns/1ps
module bscan_ir_dr #(
    parameter int N_IN = 4,
    parameter int N_OUT = 4,
    parameter int N_BIDIR = 4,
    parameter logic [10:0] MAKER_CODE = 11'h2a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5a3c, // Arbitrary value
    parameter logic [3:0] VERSION_CODE = 4'h1 // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tck,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic i_tap_reset,
    input wire logic i_capture_ir,
    input wire logic i_shift_ir,
    input wire logic i_update_ir,
    input wire logic i_capture_dr,
    input wire logic i_shift_dr,
    input wire logic i_update_dr,
    input wire logic [N_IN-1:0] i_pin_in,
    input wire logic [N_OUT-1:0] i_core_out,
    input wire logic [N_BIDIR-1:0] i_core_bd_out,
    input wire logic [N_BIDIR-1:0] i_core_bd_oe,
    input wire logic [N_BIDIR-1:0] i_pad_bd_in,
    output logic [N_OUT-1:0] o_pin_out,
    output logic [N_OUT-1:0] o_pin_oe,
    output logic [N_BIDIR-1:0] o_pad_bd_out,
    output logic [N_BIDIR-1:0] o_pad_bd_oe,
    output logic o_tdo,
    output logic o_tdo_oe,
    output logic [bscan_pkg::IR_W-1:0] o_ir
);

    localparam int OUT_BASE = N_IN;
    localparam int BD_BASE = N_IN + N_OUT;
    localparam int CHAIN_L = N_IN + N_OUT + 2 * N_BIDIR;
    localparam int W_SYNC = bscan_pkg::SYN_PIN + N_IN + N_BIDIR;
    localparam logic [bscan_pkg::ID_W-1:0] ID_VALUE =
        {VERSION_CODE, PART_CODE, MAKER_CODE, bscan_pkg::ID_FIXED_LSB};

    // Input synchronisers and test clock edges
    logic [W_SYNC-1:0] sync1_reg;
    logic [W_SYNC-1:0] sync2_reg;
    logic tck_prev_reg;
    logic [bscan_pkg::SYN_UPD_DR:bscan_pkg::SYN_TDI] ctl_prev_reg;
    logic tck_rise;
    logic tck_fall;
    logic tdi;
    logic trst_n;
    logic tap_reset;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic [N_IN-1:0] pin_in_s;
    logic [N_BIDIR-1:0] pad_bd_in_s;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_prev_reg <= 1'b0;
            ctl_prev_reg <= '0;
        end else begin
            sync1_reg <= {i_pad_bd_in, i_pin_in, i_update_dr, i_shift_dr, i_capture_dr,
                          i_update_ir, i_shift_ir, i_capture_ir, i_tap_reset, i_trst_n,
                          i_tdi, i_tck};
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg[bscan_pkg::SYN_TCK];
            ctl_prev_reg <= sync2_reg[bscan_pkg::SYN_UPD_DR:bscan_pkg::SYN_TDI];
        end
    end

    assign tck_rise = sync2_reg[bscan_pkg::SYN_TCK] & ~tck_prev_reg;
    assign tck_fall = ~sync2_reg[bscan_pkg::SYN_TCK] & tck_prev_reg;
    // Values from before the edge; controller state moves just after it
    assign tdi = ctl_prev_reg[bscan_pkg::SYN_TDI];
    assign trst_n = ctl_prev_reg[bscan_pkg::SYN_TRST_N];
    assign tap_reset = ctl_prev_reg[bscan_pkg::SYN_TAP_RESET];
    assign cap_ir = ctl_prev_reg[bscan_pkg::SYN_CAP_IR];
    assign sh_ir = ctl_prev_reg[bscan_pkg::SYN_SH_IR];
    assign upd_ir = ctl_prev_reg[bscan_pkg::SYN_UPD_IR];
    assign cap_dr = ctl_prev_reg[bscan_pkg::SYN_CAP_DR];
    assign sh_dr = ctl_prev_reg[bscan_pkg::SYN_SH_DR];
    assign upd_dr = ctl_prev_reg[bscan_pkg::SYN_UPD_DR];
    assign pin_in_s = sync2_reg[bscan_pkg::SYN_PIN +: N_IN];
    assign pad_bd_in_s = sync2_reg[bscan_pkg::SYN_PIN + N_IN +: N_BIDIR];

    // Scan state
    logic [bscan_pkg::IR_W-1:0] ir_reg;
    logic [bscan_pkg::IR_W-1:0] ir_next;
    logic [bscan_pkg::IR_W-1:0] ir_sh_reg;
    logic [bscan_pkg::IR_W-1:0] ir_sh_next;
    logic byp_reg;
    logic byp_next;
    logic [bscan_pkg::ID_W-1:0] id_sh_reg;
    logic [bscan_pkg::ID_W-1:0] id_sh_next;
    logic [CHAIN_L-1:0] chain_sh_reg;
    logic [CHAIN_L-1:0] chain_sh_next;
    logic [CHAIN_L-1:0] chain_up_reg;
    logic [CHAIN_L-1:0] chain_up_next;
    logic [CHAIN_L-1:0] cap_vec;
    logic tdo_reg;
    logic tdo_next;
    logic tdo_oe_reg;
    logic tdo_oe_next;
    // Instruction decode
    bscan_pkg::dr_sel_t sel;
    logic ext;
    logic clamp;
    logic highz;
    logic chain_ctl;

    always_comb begin
        sel = bscan_pkg::SEL_BYPASS;
        ext = 1'b0;
        clamp = 1'b0;
        highz = 1'b0;
        case (ir_reg)
            bscan_pkg::OP_EXTEST: begin
                sel = bscan_pkg::SEL_CHAIN;
                ext = 1'b1;
            end
            bscan_pkg::OP_SAMPLE: begin
                sel = bscan_pkg::SEL_CHAIN;
            end
            bscan_pkg::OP_IDCODE: begin
                sel = bscan_pkg::SEL_ID;
            end
            bscan_pkg::OP_HIGHZ: begin
                highz = 1'b1;
            end
            bscan_pkg::OP_CLAMP: begin
                clamp = 1'b1;
            end
            default: begin
                sel = bscan_pkg::SEL_BYPASS;
            end
        endcase
    end

    assign chain_ctl = ext | clamp;
    // Boundary cells
    logic [N_OUT-1:0] pin_out_d;
    logic [N_OUT-1:0] pin_oe_d;
    logic [N_BIDIR-1:0] bd_out_d;
    logic [N_BIDIR-1:0] bd_oe_d;

    genvar g;
    generate
        for (g = 0; g < N_IN; g++) begin : g_in
            assign cap_vec[g] = pin_in_s[g];
        end
        for (g = 0; g < N_OUT; g++) begin : g_out
            assign cap_vec[OUT_BASE+g] = o_pin_out[g];
            assign pin_out_d[g] = chain_ctl ? chain_up_reg[OUT_BASE+g] : i_core_out[g];
            assign pin_oe_d[g] = ~highz;
        end
        for (g = 0; g < N_BIDIR; g++) begin : g_bd
            // Enable cell, then single-register capture cell
            assign cap_vec[BD_BASE+2*g] = o_pad_bd_oe[g];
            assign cap_vec[BD_BASE+2*g+1] = (!ext && i_core_bd_oe[g]) ?
                i_core_bd_out[g] : pad_bd_in_s[g];
            assign bd_out_d[g] = chain_ctl ? chain_up_reg[BD_BASE+2*g+1] : i_core_bd_out[g];
            assign bd_oe_d[g] = highz ? 1'b0 :
                (chain_ctl ? chain_up_reg[BD_BASE+2*g] : i_core_bd_oe[g]);
        end
    endgenerate

    always_comb begin
        ir_next = ir_reg;
        ir_sh_next = ir_sh_reg;
        byp_next = byp_reg;
        id_sh_next = id_sh_reg;
        chain_sh_next = chain_sh_reg;
        chain_up_next = chain_up_reg;
        tdo_next = tdo_reg;
        tdo_oe_next = tdo_oe_reg;
        if (tck_rise) begin
            if (cap_ir) begin
                ir_sh_next = bscan_pkg::IR_CAPTURE_PATTERN;
            end else if (sh_ir) begin
                ir_sh_next = {tdi, ir_sh_reg[bscan_pkg::IR_W-1:1]};
            end
            if (cap_dr) begin
                case (sel)
                    bscan_pkg::SEL_CHAIN: chain_sh_next = cap_vec;
                    bscan_pkg::SEL_ID: id_sh_next = ID_VALUE;
                    default: byp_next = 1'b0;
                endcase
            end else if (sh_dr) begin
                case (sel)
                    bscan_pkg::SEL_CHAIN: chain_sh_next = {tdi, chain_sh_reg[CHAIN_L-1:1]};
                    bscan_pkg::SEL_ID: id_sh_next = {tdi, id_sh_reg[bscan_pkg::ID_W-1:1]};
                    default: byp_next = tdi;
                endcase
            end
        end
        if (tck_fall) begin
            if (upd_ir) begin
                ir_next = ir_sh_reg;
            end
            if (upd_dr && sel == bscan_pkg::SEL_CHAIN) begin
                chain_up_next = chain_sh_reg;
            end
            tdo_oe_next = sh_ir | sh_dr;
            if (sh_ir) begin
                tdo_next = ir_sh_reg[0];
            end else begin
                case (sel)
                    bscan_pkg::SEL_CHAIN: tdo_next = chain_sh_reg[0];
                    bscan_pkg::SEL_ID: tdo_next = id_sh_reg[0];
                    default: tdo_next = byp_reg;
                endcase
            end
        end
        if (!trst_n || tap_reset) begin
            ir_next = bscan_pkg::OP_IDCODE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_reg <= bscan_pkg::OP_IDCODE;
            ir_sh_reg <= bscan_pkg::OP_IDCODE;
            byp_reg <= 1'b0;
            id_sh_reg <= '0;
            chain_sh_reg <= '0;
            chain_up_reg <= '0;
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_pad_bd_out <= '0;
            o_pad_bd_oe <= '0;
        end else begin
            ir_reg <= ir_next;
            ir_sh_reg <= ir_sh_next;
            byp_reg <= byp_next;
            id_sh_reg <= id_sh_next;
            chain_sh_reg <= chain_sh_next;
            chain_up_reg <= chain_up_next;
            tdo_reg <= tdo_next;
            tdo_oe_reg <= tdo_oe_next;
            o_pin_out <= pin_out_d;
            o_pin_oe <= pin_oe_d;
            o_pad_bd_out <= bd_out_d;
            o_pad_bd_oe <= bd_oe_d;
        end
    end

    assign o_tdo = tdo_reg;
    assign o_tdo_oe = tdo_oe_reg;
    assign o_ir = ir_reg;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic [N_OUT-1:0] up_out_vec;
    assign up_out_vec = chain_up_reg[OUT_BASE +: N_OUT];

    a_ir_capture_load: assert property (
        tck_rise && cap_ir |=> ir_sh_reg == bscan_pkg::IR_CAPTURE_PATTERN)
        else $error("instruction capture pattern not loaded");
    a_ir_shift_bit: assert property (
        tck_rise && sh_ir && !cap_ir |=> ir_sh_reg[bscan_pkg::IR_W-1] == $past(tdi)
            && ir_sh_reg[bscan_pkg::IR_W-2:0] == $past(ir_sh_reg[bscan_pkg::IR_W-1:1]))
        else $error("instruction shift wrong");
    a_ir_held_until_update: assert property (
        !(tck_fall && upd_ir) && trst_n && !tap_reset |=> $stable(ir_reg))
        else $error("instruction changed outside update");
    a_reset_gives_id: assert property (
        !trst_n ##1 !trst_n |-> ir_reg == bscan_pkg::OP_IDCODE)
        else $error("test reset did not select identification");
    a_bypass_zero: assert property (
        tck_rise && cap_dr && sel == bscan_pkg::SEL_BYPASS |=> byp_reg == 1'b0)
        else $error("bypass bit not cleared at capture");
    a_id_capture_value: assert property (
        tck_rise && cap_dr && sel == bscan_pkg::SEL_ID |=> id_sh_reg == ID_VALUE
            && id_sh_reg[0] == bscan_pkg::ID_FIXED_LSB)
        else $error("identification value wrong");
    a_highz_pins_off: assert property (
        highz |=> o_pin_oe == '0 && o_pad_bd_oe == '0)
        else $error("pins driven in high impedance mode");
    a_extest_drives_latch: assert property (
        chain_ctl |=> o_pin_out == $past(up_out_vec))
        else $error("pins not driven from chain latches");
    a_sample_no_drive: assert property (
        ir_reg == bscan_pkg::OP_SAMPLE |=> o_pin_out == $past(i_core_out))
        else $error("sample disturbed the pins");
    a_tdo_on_fall: assert property (
        $changed(tdo_reg) || $changed(tdo_oe_reg) |-> $past(tck_fall))
        else $error("serial out changed off the falling edge");
    a_latch_on_fall: assert property (
        $changed(chain_up_reg) |-> $past(tck_fall && upd_dr && sel == bscan_pkg::SEL_CHAIN))
        else $error("chain latch changed off update fall");
    a_bidir_core_data: assert property (
        tck_rise && cap_dr && sel == bscan_pkg::SEL_CHAIN && !ext && i_core_bd_oe[0]
            |=> chain_sh_reg[BD_BASE+1] == $past(i_core_bd_out[0]))
        else $error("bidirectional capture missed core data");
    a_bidir_pad_data: assert property (
        tck_rise && cap_dr && sel == bscan_pkg::SEL_CHAIN && (ext || !i_core_bd_oe[0])
            |=> chain_sh_reg[BD_BASE+1] == $past(pad_bd_in_s[0]))
        else $error("bidirectional capture missed pad data");

    c_extest_entered: cover property (
        tck_fall && upd_ir && ir_sh_reg == bscan_pkg::OP_EXTEST);
    c_id_shift: cover property (tck_rise && sh_dr && sel == bscan_pkg::SEL_ID);
    c_highz_active: cover property (highz ##1 o_pad_bd_oe == '0);
    c_bypass_shift: cover property (tck_rise && sh_dr && sel == bscan_pkg::SEL_BYPASS);

endmodule : bscan_ir_dr

//--- test/bscan_tester.sv
`timescale 1ns/1ps
module bscan_tester (
    output logic o_tck,
    output logic o_tdi,
    output logic o_trst_n,
    output logic o_tap_reset,
    output logic [5:0] o_st
);
    // State bits: 0 cap_ir, 1 sh_ir, 2 upd_ir, 3 cap_dr, 4 sh_dr, 5 upd_dr
    initial begin
        o_tck = 1'b0;
        o_tdi = 1'b1;
        o_trst_n = 1'b1;
        o_tap_reset = 1'b0;
        o_st = 6'h00;
    end
    // One test clock period, states change just after the rise
    task automatic cycle(input logic [5:0] st, input logic d);
        o_tck = 1'b1;
        #2;
        o_st = st;
        o_tdi = (st[1] | st[4]) ? d : ~o_tdi; // Toggles when not shifting
        #78;
        o_tck = 1'b0;
        #80;
    endtask : cycle
    // Capture, n shifts LSB first, update; clock then stands low
    task automatic scan(input bit dr, input int n, input logic [31:0] din);
        cycle(dr ? 6'h08 : 6'h01, 1'b0);
        for (int i = 0; i < n; i++) begin
            cycle(dr ? 6'h10 : 6'h02, din[i]);
        end
        cycle(dr ? 6'h20 : 6'h04, 1'b0);
        o_st = 6'h00;
    endtask : scan
    task automatic test_reset(input bit by_pin);
        o_trst_n = !by_pin;
        o_tap_reset = !by_pin;
        #200;
        o_trst_n = 1'b1;
        o_tap_reset = 1'b0;
    endtask : test_reset
endmodule : bscan_tester

//--- test/test_bscan_ir_dr.sv
`timescale 1ns/1ps
module test_bscan_ir_dr;
    localparam logic [31:0] ID_VALUE = {4'h1, 16'h5a3c, 11'h2a5, 1'b1};
    logic i_clk;
    logic i_rst_n;
    logic tck, tdi, trst_n, tap_reset;
    logic [5:0] st;
    logic [1:0] i_pin_in;
    logic [1:0] i_core_out;
    logic [1:0] i_core_bd_out;
    logic [1:0] i_core_bd_oe;
    logic [1:0] pad_drv;
    wire logic [1:0] i_pad_bd_in;
    wire logic [1:0] o_pin_out, o_pin_oe, o_pad_bd_out, o_pad_bd_oe;
    wire logic o_tdo, o_tdo_oe;
    wire logic [5:0] o_ir;
    logic [31:0] lfsr = 32'hc5182710;
    logic [7:0] p, cap;
    logic [1:0] d;
    logic [5:0] ops [6];
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic q[$];
    // Pad level: device driver wins when enabled, board otherwise
    assign i_pad_bd_in = (o_pad_bd_oe & o_pad_bd_out) | (~o_pad_bd_oe & pad_drv);
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    bscan_tester bscan_tester_inst (.o_tck(tck), .o_tdi(tdi), .o_trst_n(trst_n),
        .o_tap_reset(tap_reset), .o_st(st));
    bscan_ir_dr #(.N_IN(2), .N_OUT(2), .N_BIDIR(2), .MAKER_CODE(11'h2a5),
        .PART_CODE(16'h5a3c), .VERSION_CODE(4'h1)) bscan_ir_dr_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tdi(tdi), .i_trst_n(trst_n),
        .i_tap_reset(tap_reset), .i_capture_ir(st[0]), .i_shift_ir(st[1]),
        .i_update_ir(st[2]), .i_capture_dr(st[3]), .i_shift_dr(st[4]),
        .i_update_dr(st[5]), .i_pin_in(i_pin_in), .i_core_out(i_core_out),
        .i_core_bd_out(i_core_bd_out), .i_core_bd_oe(i_core_bd_oe),
        .i_pad_bd_in(i_pad_bd_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pad_bd_out(o_pad_bd_out), .o_pad_bd_oe(o_pad_bd_oe), .o_tdo(o_tdo),
        .o_tdo_oe(o_tdo_oe), .o_ir(o_ir));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic expect_bits(input int n, input logic [31:0] v);
        for (int i = 0; i < n; i++) begin
            q.push_back(v[i]);
        end
    endtask : expect_bits
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr_next
    // New random board and core values, driven after the clock edge
    task automatic rand_in();
        @(posedge i_clk);
        #2;
        lfsr = lfsr_next(lfsr);
        {pad_drv, i_core_bd_oe, i_core_bd_out, i_core_out, i_pin_in} = lfsr[9:0];
        p = lfsr[23:16];
        d = lfsr[27:26];
    endtask : rand_in
    task automatic settle();
        repeat (8) @(posedge i_clk);
        #2;
    endtask : settle
    task automatic ir_load(input logic [5:0] op);
        expect_bits(6, 32'(bscan_pkg::IR_CAPTURE_PATTERN));
        bscan_tester_inst.scan(1'b0, 6, 32'(op));
        settle();
        check(32'(o_ir), 32'(op), "instruction");
    endtask : ir_load
    task automatic check_pins(input logic [7:0] exp);
        check(32'({o_pin_out, o_pin_oe, o_pad_bd_out, o_pad_bd_oe}), 32'(exp), "pins");
    endtask : check_pins
    // Serial watcher: one bit per test clock fall while the output is driven
    initial begin
        forever begin
            @(negedge tck);
            #140;
            if (o_tdo_oe === 1'b1 && q.size() == 0) begin
                check(32'(o_tdo), 32'h2, "unexpected serial bit");
            end else if (o_tdo_oe === 1'b1) begin
                check(32'(o_tdo), 32'(q.pop_front()), "serial bit");
            end
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            test_done();
        end
    end
    initial begin
        i_rst_n = 1'b0;
        {pad_drv, i_core_bd_oe, i_core_bd_out, i_core_out, i_pin_in} = 10'h000;
        ops = '{bscan_pkg::OP_BYPASS, bscan_pkg::OP_HIGHZ, 6'h04, 6'h2c, 6'h2e, 6'h3d};
        repeat (6) @(posedge i_clk);
        #2;
        i_rst_n = 1'b1;
        settle();
        check(32'(o_ir), 32'(bscan_pkg::OP_IDCODE), "reset instruction");
        expect_bits(32, ID_VALUE);
        bscan_tester_inst.scan(1'b1, 32, lfsr);
        foreach (ops[i]) begin
            rand_in();
            ir_load(ops[i]);
            expect_bits(2, {30'h0, d[0], 1'b0});
            bscan_tester_inst.scan(1'b1, 2, 32'(d));
            if (ops[i] == bscan_pkg::OP_HIGHZ) begin
                check(32'({o_pin_oe, o_pad_bd_oe}), 32'h0, "high-z enables");
            end else begin
                check_pins({i_core_out, 2'b11, i_core_bd_out, i_core_bd_oe});
            end
        end
        rand_in();
        ir_load(bscan_pkg::OP_SAMPLE);
        cap = {i_core_bd_oe[1] ? i_core_bd_out[1] : pad_drv[1], i_core_bd_oe[1],
            i_core_bd_oe[0] ? i_core_bd_out[0] : pad_drv[0], i_core_bd_oe[0],
            i_core_out, i_pin_in};
        expect_bits(8, 32'(cap));
        bscan_tester_inst.scan(1'b1, 8, 32'(p));
        settle();
        check_pins({i_core_out, 2'b11, i_core_bd_out, i_core_bd_oe});
        // Chain preloaded above before external test is selected
        ir_load(bscan_pkg::OP_EXTEST);
        check_pins({p[3:2], 2'b11, p[7], p[5], p[6], p[4]});
        lfsr = lfsr_next(lfsr);
        {pad_drv, i_core_bd_oe, i_core_bd_out, i_core_out, i_pin_in} = lfsr[9:0];
        settle();
        cap = {p[6] ? p[7] : pad_drv[1], p[6], p[4] ? p[5] : pad_drv[0], p[4], p[3:2], i_pin_in};
        expect_bits(8, 32'(cap));
        bscan_tester_inst.scan(1'b1, 8, 32'(p));
        settle();
        check_pins({p[3:2], 2'b11, p[7], p[5], p[6], p[4]});
        ir_load(bscan_pkg::OP_CLAMP);
        expect_bits(2, {30'h0, d[1], 1'b0});
        bscan_tester_inst.scan(1'b1, 2, {30'h0, ~d[1], d[1]});
        settle();
        check_pins({p[3:2], 2'b11, p[7], p[5], p[6], p[4]});
        bscan_tester_inst.test_reset(1'b1);
        settle();
        check(32'(o_ir), 32'(bscan_pkg::OP_IDCODE), "test reset pin");
        ir_load(bscan_pkg::OP_BYPASS);
        bscan_tester_inst.test_reset(1'b0);
        settle();
        check(32'(o_ir), 32'(bscan_pkg::OP_IDCODE), "tap reset state");
        check(32'(q.size()), 32'h0, "pending serial bits");
        test_done();
    end
endmodule : test_bscan_ir_dr
